// ---- serial_port_control_status_bench.sv ----
// Self-checking bench for the serial port control and status block.
// Assumes spcs_top with a partner on the serial data pins.
module serial_port_control_status_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        aclk, aresetn, low_power, awvalid, wvalid, bready, arvalid;
   logic        rready, awready, wready, bvalid, arready, rvalid, txd, rxd;
   logic        rxd_pin_serial, sck_out, sck_oe_n, tx_done_irq, sck_in;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   int          failures, checks_done;
   spcs_top dut (.aclk, .aresetn, .low_power, .awaddr, .awvalid, .awready,
      .wdata, .wstrb(4'h1), .wvalid, .wready, .bresp, .bvalid, .bready,
      .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .txd,
      .rxd, .rxd_pin_serial, .sck_in, .sck_out, .sck_oe_n,
      .tx_empty_irq(), .rx_full_irq(), .rx_fault_irq(), .tx_done_irq);
   spcs_peer peer (.aclk, .txd, .rxd);
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   initial begin
      sck_in = 1'b0;
      forever #200 sck_in = ~sck_in; // link clock 16x bit rate
   end
   task automatic test_done();
      if (failures == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic tick(inout int n);
      @(posedge aclk);
      n++;
      if (n > 4000) begin
         chk(n, 0);
         test_done();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      int n = 0;
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do tick(n); while (!(awready === 1'b1 && wready === 1'b1));
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do tick(n); while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk(bresp, {a > spcs_pkg::RXB_OFS, 1'b0});
      @(posedge aclk);
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      int n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do tick(n); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do tick(n); while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk(rdata, {24'h0, e});
      chk(rresp, {a > spcs_pkg::RXB_OFS, 1'b0});
      @(posedge aclk);
   endtask
   task automatic t_reset();
      rc(spcs_pkg::STAT_OFS, spcs_pkg::STAT_RST);
      wr(8'h18, 8'h55);
      rc(8'h18, 8'h00);
      wr(spcs_pkg::TXB_OFS, 8'h5a);
      rc(spcs_pkg::STAT_OFS, 8'h84);
      chk(peer.frames, 0);
   endtask
   task automatic t_tx();
      int n = 0;
      wr(spcs_pkg::CTRL_OFS, 8'h24);
      wr(spcs_pkg::TXB_OFS, 8'ha5);
      wr(spcs_pkg::TXB_OFS, 8'h3c);
      rc(spcs_pkg::STAT_OFS, 8'h00);
      while (peer.frames < 1) tick(n);
      chk(peer.got, 8'ha5);
      repeat (16) @(posedge aclk);
      rc(spcs_pkg::STAT_OFS, 8'h80);
      while (peer.frames < 2) tick(n);
      chk(peer.got, 8'h3c);
      while (tx_done_irq !== 1'b1) tick(n);
      rc(spcs_pkg::STAT_OFS, 8'h84);
      wr(spcs_pkg::CTRL_OFS, 8'h20);
      @(posedge aclk);
      chk(tx_done_irq, 1'b0);
   endtask
   task automatic t_rx();
      wr(spcs_pkg::CTRL_OFS, 8'h10);
      peer.send(9'h0c3, 8);
      wr(spcs_pkg::STAT_OFS, 8'h00);
      rc(spcs_pkg::STAT_OFS, 8'hc4);
      wr(spcs_pkg::STAT_OFS, 8'hff);
      rc(spcs_pkg::STAT_OFS, 8'hc5);
      wr(spcs_pkg::STAT_OFS, 8'h80);
      rc(spcs_pkg::STAT_OFS, 8'h84);
      rc(spcs_pkg::RXB_OFS, 8'hc3);
      peer.send(9'h00f, 8);
      wr(spcs_pkg::CTRL_OFS, 8'h00);
      chk(rxd_pin_serial, 1'b0);
      rc(spcs_pkg::STAT_OFS, 8'hc4);
      rc(spcs_pkg::RXB_OFS, 8'h0f);
   endtask
   task automatic t_multi();
      // format after clock select, before enabling.
      wr(spcs_pkg::FMT_OFS, 8'h04);
      wr(spcs_pkg::CTRL_OFS, 8'h18);
      peer.send(9'h055, 9);
      rc(spcs_pkg::STAT_OFS, 8'h84);
      peer.send(9'h1aa, 9);
      rc(spcs_pkg::STAT_OFS, 8'hc6);
      rc(spcs_pkg::CTRL_OFS, 8'h10);
      rc(spcs_pkg::RXB_OFS, 8'haa);
      wr(spcs_pkg::FMT_OFS, 8'h00);
      wr(spcs_pkg::CTRL_OFS, 8'h18);
      peer.send(9'h033, 8);
      rc(spcs_pkg::RXB_OFS, 8'h33);
   endtask
   task automatic t_pins();
      int n = 0;
      int t;
      wr(spcs_pkg::CTRL_OFS, 8'h22);
      chk(sck_oe_n, 1'b1);
      wr(spcs_pkg::TXB_OFS, 8'hfa);
      do tick(n); while (txd !== 1'b0);
      do tick(n); while (txd !== 1'b1);
      t = n;
      do tick(n); while (txd !== 1'b0);
      chk(n - t, 128);
      wr(spcs_pkg::CTRL_OFS, 8'h01);
      chk(sck_oe_n, 1'b0);
      do tick(n); while (sck_out !== 1'b0);
      do tick(n); while (sck_out !== 1'b1);
      t = n;
      do tick(n); while (sck_out !== 1'b0);
      do tick(n); while (sck_out !== 1'b1);
      chk(n - t, 16);
      wr(spcs_pkg::CTRL_OFS, 8'h00);
      chk(sck_oe_n, 1'b1);
      wr(spcs_pkg::FMT_OFS, 8'h80); // clock bits set first
      chk(sck_oe_n, 1'b0);
      wr(spcs_pkg::CTRL_OFS, 8'h10);
      wr(spcs_pkg::STAT_OFS, 8'h01);
      low_power <= 1'b1;
      @(posedge aclk);
      low_power <= 1'b0;
      @(posedge aclk);
      rc(spcs_pkg::STAT_OFS, spcs_pkg::STAT_RST);
      rc(spcs_pkg::CTRL_OFS, 8'h00);
   endtask
   initial begin
      {aresetn, low_power, awvalid, wvalid, bready, arvalid, rready} = '0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      failures = 0;
      checks_done = 0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_tx();
      t_rx();
      t_multi();
      t_pins();
      test_done();
   end
endmodule

// ---- spcs_checker_assertions.sv ----
// Port checker for the serial port block, bound into spcs_top.
// Assumes one aclk domain with a synchronous active-low reset.
module spcs_checker (
   input logic aclk,
   input logic aresetn,
   input logic low_power,
   input logic awvalid,
   input logic awready,
   input logic wvalid,
   input logic wready,
   input logic bvalid,
   input logic arvalid,
   input logic arready,
   input logic rvalid,
   input logic txd,
   input logic rxd_pin_serial,
   input logic sck_oe_n,
   input logic tx_done_irq
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   reset_idle_a: assert property ($rose(aresetn) |-> txd && sck_oe_n)
      else $error("pins not idle after reset");
   power_idle_a: assert property ($past(low_power) |-> txd && sck_oe_n
      && !rxd_pin_serial) else $error("pins not idle after low power");
   write_time_a: assert property (awvalid && wvalid && !awready && !bvalid
      |=> awready && wready ##1 bvalid && !awready)
      else $error("write answer late");
   read_time_a: assert property (arvalid && !arready && !rvalid
      |=> arready ##1 rvalid && !arready) else $error("read answer late");
   bresp_cause_a: assert property ($rose(bvalid) |-> $past(awready)
      && $past(wready)) else $error("response without handshake");
   rresp_cause_a: assert property ($rose(rvalid) |-> $past(arready))
      else $error("read data without handshake");
   done_rise_a: assert property ($rose(tx_done_irq) |-> txd && $past(txd, 2))
      else $error("transmit end during a bit");
   done_fall_a: assert property ($fell(tx_done_irq) |-> $past(bvalid)
      || $past(bvalid, 2) || $past(bvalid, 3) || $past(low_power))
      else $error("transmit end dropped alone");
endmodule
bind spcs_top spcs_checker chk (.aclk, .aresetn, .low_power, .awvalid,
   .awready, .wvalid, .wready, .bvalid, .arvalid, .arready, .rvalid, .txd,
   .rxd_pin_serial, .sck_oe_n, .tx_done_irq);

// ---- spcs_peer.sv ----
// Remote asynchronous partner: start bit, LSB first, then a stop bit.
// Assumes 16 aclk cycles per bit; its line idles high between frames.
module spcs_peer (
   input  logic aclk,
   input  logic txd,
   output logic rxd
);
   timeunit 1ns;
   timeprecision 1ns;
   int         frames = 0;
   logic [7:0] got;
   initial rxd = 1'b1;
   task automatic send(input logic [8:0] f, input int n);
      rxd <= 1'b0;
      repeat (16) @(posedge aclk);
      for (int i = 0; i < n; i++) begin
         rxd <= f[i];
         repeat (16) @(posedge aclk);
      end
      rxd <= 1'b1;
      repeat (40) @(posedge aclk);
   endtask
   // Samples each data bit at its middle.
   always begin
      @(negedge txd);
      repeat (8) @(posedge aclk);
      for (int i = 0; i < 8; i++) begin
         repeat (16) @(posedge aclk);
         got[i] = txd;
      end
      repeat (16) @(posedge aclk);
      frames++;
   end
endmodule

// ---- spcs_pkg.sv ----
// Register map, reset values, field layouts and states of the serial port.
// Assumes a 32-bit AXI4-Lite register bus clocked by the system clock.
package spcs_pkg;
   localparam logic [7:0] FMT_OFS     = 8'h00;
   localparam logic [7:0] RATE_OFS    = 8'h04;
   localparam logic [7:0] CTRL_OFS    = 8'h08;
   localparam logic [7:0] TXB_OFS     = 8'h0c;
   localparam logic [7:0] STAT_OFS    = 8'h10;
   localparam logic [7:0] RXB_OFS     = 8'h14;
   localparam logic [7:0] FMT_RST     = 8'h00;
   localparam logic [7:0] RATE_RST    = 8'h00;
   localparam logic [7:0] TXB_RST     = 8'hff;
   localparam logic [7:0] CTRL_RST    = 8'h00;
   localparam logic [7:0] STAT_RST    = 8'h84;
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   localparam logic [3:0] OS_MID      = 4'h7;
   localparam logic [3:0] OS_LAST     = 4'hf;
   localparam logic [3:0] BITS_SYNC   = 4'h8;
   localparam logic [1:0] CK_INT_IO   = 2'b00;
   localparam logic [1:0] CK_INT_OUT  = 2'b01;
   localparam logic [1:0] CK_EXT      = 2'b10;

   typedef struct packed {
      logic       sync_mode;
      logic       char7;
      logic       parity_en;
      logic       parity_odd;
      logic       stop2;
      logic       multi_cpu_mode;
      logic [1:0] prescale;
   } spcs_fmt_t;

   typedef struct packed {
      logic tx_empty_irq_enable;
      logic rx_irq_enable;
      logic tx_enable;
      logic rx_enable;
      logic multi_cpu_wait_enable;
      logic tx_done_irq_enable;
      logic clk_src_external;
      logic clk_out_select;
   } spcs_ctrl_t;

   typedef struct packed {
      logic tx_buffer_empty;
      logic rx_buffer_full;
      logic overrun_flag;
      logic framing_flag;
      logic parity_flag;
      logic tx_complete_flag;
      logic multi_cpu_bit_received;
      logic multi_cpu_bit_to_send;
   } spcs_stat_t;

   typedef enum logic [1:0] {
      TX_IDLE  = 2'b00,
      TX_SHIFT = 2'b01
   } spcs_tx_st_t;

   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b10
   } spcs_rx_st_t;
endpackage

// ---- spcs_top.sv ----
// Serial port control and status with transmitter, receiver and clocking.
// Assumes an AXI4-Lite master on aclk; pins come from outside the domain.
// How it works
// [R1] Transmit disabled: idle line, empty flag set.
// [R2] Buffer write with enable starts sending.
// [R3] Software sets format before enabling.
// [R4] Receive off: pin freed, flags kept.
// [R5] Start bit or clock edge begins reception.
// [R6] Wait enable only in asynchronous multiprocessor.
// [R7] Waiting drops characters with bit zero.
// [R8] Bit one: flag set, waiting ends.
// [R9] Transmit end raised when nothing waits.
// [R10] Transmit end falls with flags or enable.
// [R11] Asynchronous clock select codes.
// [R12] Synchronous clock select codes.
// [R13] Clock output runs at bit rate.
// [R14] External asynchronous clock is sixteen times.
// [R15] Software keeps clock output off otherwise.
// [R16] Clock select written before mode.
// [R17] Status resets to 84 hex.
// [R18] Flags clear by zero after read.
// [R19] Complete and received bit read-only.
// [R20] Empty flag set on transfer or disable.
// [R21] Buffer write clears empty flag while transmit is enabled.
// [R22] Clean character sets receive full.
// [R23] Per flag record of a read one.
module spcs_top #(
   parameter int unsigned ADDR_W = 8
) (
   input  logic              aclk,
   input  logic              aresetn,
   input  logic              low_power,
   input  logic [ADDR_W-1:0] awaddr,
   input  logic              awvalid,
   output logic              awready,
   input  logic [31:0]       wdata,
   input  logic [3:0]        wstrb,
   input  logic              wvalid,
   output logic              wready,
   output logic [1:0]        bresp,
   output logic              bvalid,
   input  logic              bready,
   input  logic [ADDR_W-1:0] araddr,
   input  logic              arvalid,
   output logic              arready,
   output logic [31:0]       rdata,
   output logic [1:0]        rresp,
   output logic              rvalid,
   input  logic              rready,
   output logic              txd,
   input  logic              rxd,
   output logic              rxd_pin_serial,
   input  logic              sck_in,
   output logic              sck_out,
   output logic              sck_oe_n,
   output logic              tx_empty_irq,
   output logic              rx_full_irq,
   output logic              rx_fault_irq,
   output logic              tx_done_irq
);
   spcs_pkg::spcs_fmt_t   fmt_q;
   spcs_pkg::spcs_ctrl_t  ctrl_q;
   spcs_pkg::spcs_stat_t  stat_q;
   spcs_pkg::spcs_stat_t  stat_d;
   spcs_pkg::spcs_tx_st_t tx_st_q;
   spcs_pkg::spcs_rx_st_t rx_st_q;
   logic [7:0]  rate_q, txb_q, rxb_q, rdata_q, rd_val, div_q, rx_data;
   logic [4:0]  arm_q, wclr;
   logic [1:0]  pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q, bresp_q, rresp_q;
   logic [1:0]  ck_sel;
   logic [5:0]  pre_q;
   logic [11:0] tx_sh_q;
   logic [9:0]  rx_bits_q, rx_full;
   logic [3:0]  ck_os_q, tx_left_q, tx_os_q, rx_idx_q, rx_os_q, rx_n, irq_q;
   logic        clr, sck_p_q, rxd_f, sck_f, txd_q, rxps_q, sck_out_q;
   logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic        wlane, w_fmt, w_rate, w_ctrl, w_txb, w_stat, rd_stat, rd_rxb;
   logic        pre_tick, base_tick, sync, ext_rise, int_sck_q, run;
   logic        sck_rise, os_tick, tx_bit_ev, tx_last, tx_load, sck_oe_n_q;
   logic        rx_ok, rx_take, rx_done, rx_ex, rx_extra, rx_stop, rx_fill;
   logic        mp_act, rx_drop, rx_keep, set_oer, set_fer, set_per;

   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [7:0]        o);
      return a == ADDR_W'(o);
   endfunction

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      return hit(a, spcs_pkg::FMT_OFS) || hit(a, spcs_pkg::RATE_OFS) ||
             hit(a, spcs_pkg::CTRL_OFS) || hit(a, spcs_pkg::TXB_OFS) ||
             hit(a, spcs_pkg::STAT_OFS) || hit(a, spcs_pkg::RXB_OFS);
   endfunction

   function automatic logic [5:0] pre_mask(input logic [1:0] s);
      case (s)
         2'b00:   return 6'h00;
         2'b01:   return 6'h03;
         2'b10:   return 6'h0f;
         default: return 6'h3f;
      endcase
   endfunction

   function automatic logic [3:0] data_bits(input spcs_pkg::spcs_fmt_t f);
      return (f.char7 && !f.sync_mode) ? 4'h7 : 4'h8;
   endfunction

   function automatic logic has_extra(input spcs_pkg::spcs_fmt_t f);
      return !f.sync_mode && (f.parity_en || f.multi_cpu_mode);
   endfunction

   // Bits after the start bit up to and including the first stop bit.
   function automatic logic [3:0] frame_bits(input spcs_pkg::spcs_fmt_t f);
      if (f.sync_mode) begin
         return spcs_pkg::BITS_SYNC;
      end
      return data_bits(f) + {3'h0, has_extra(f)} + 4'h1;
   endfunction

   function automatic logic parity(input spcs_pkg::spcs_fmt_t f,
                                   input logic [7:0]          d);
      return (^(f.char7 ? {1'b0, d[6:0]} : d)) ^ f.parity_odd;
   endfunction

   function automatic logic [11:0] tx_frame(input spcs_pkg::spcs_fmt_t f,
                                            input logic [7:0]          d,
                                            input logic                mb);
      logic [11:0] v;
      logic [3:0]  n;
      v = 12'hfff;
      n = data_bits(f);
      if (f.sync_mode) begin
         v = {4'hf, d};
      end else begin
         v[0] = 1'b0;
         for (int i = 0; i < 8; i++) begin
            if (4'(i) < n) v[i+1] = d[i];
         end
         if (f.multi_cpu_mode) v[n+4'h1] = mb;
         else if (f.parity_en) v[n+4'h1] = parity(f, d);
      end
      return v;
   endfunction

   // Standby and similar modes clear control and status like a reset.
   assign clr = !aresetn || low_power;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_s1_q <= 2'b11;
         pin_s2_q <= 2'b11;
         pin_s3_q <= 2'b11;
         pin_f_q  <= 2'b11;
         sck_p_q  <= 1'b1;
      end else begin
         pin_s1_q <= {sck_in, rxd};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
         pin_f_q  <= (pin_s2_q & pin_s3_q) |
                     (pin_f_q & (pin_s2_q | pin_s3_q));
         sck_p_q  <= pin_f_q[1];
      end
   end
   assign rxd_f = pin_f_q[0];
   assign sck_f = pin_f_q[1];

   assign wlane   = awready_q && wstrb[0];
   assign w_fmt   = wlane && hit(awaddr, spcs_pkg::FMT_OFS);
   assign w_rate  = wlane && hit(awaddr, spcs_pkg::RATE_OFS);
   assign w_ctrl  = wlane && hit(awaddr, spcs_pkg::CTRL_OFS);
   assign w_txb   = wlane && hit(awaddr, spcs_pkg::TXB_OFS);
   assign w_stat  = wlane && hit(awaddr, spcs_pkg::STAT_OFS);
   assign rd_stat = arready_q && hit(araddr, spcs_pkg::STAT_OFS);
   assign rd_rxb  = arready_q && hit(araddr, spcs_pkg::RXB_OFS);

   always_comb begin
      rd_val = 8'h00;
      if (hit(araddr, spcs_pkg::FMT_OFS)) rd_val = fmt_q;
      if (hit(araddr, spcs_pkg::RATE_OFS)) rd_val = rate_q;
      if (hit(araddr, spcs_pkg::CTRL_OFS)) rd_val = ctrl_q;
      if (hit(araddr, spcs_pkg::TXB_OFS)) rd_val = txb_q;
      if (hit(araddr, spcs_pkg::STAT_OFS)) rd_val = stat_q;
      if (hit(araddr, spcs_pkg::RXB_OFS)) rd_val = rxb_q;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= spcs_pkg::RESP_OKAY;
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rresp_q   <= spcs_pkg::RESP_OKAY;
         rdata_q   <= 8'h00;
      end else begin
         awready_q <= awvalid && wvalid && !awready_q && !bvalid_q;
         wready_q  <= awvalid && wvalid && !awready_q && !bvalid_q;
         if (awready_q) begin
            bvalid_q <= 1'b1;
            bresp_q  <= mapped(awaddr) ? spcs_pkg::RESP_OKAY
                                       : spcs_pkg::RESP_SLVERR;
         end else if (bready) begin
            bvalid_q <= 1'b0;
         end
         arready_q <= arvalid && !arready_q && !rvalid_q;
         if (arready_q) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_val;
            rresp_q  <= mapped(araddr) ? spcs_pkg::RESP_OKAY
                                       : spcs_pkg::RESP_SLVERR;
         end else if (rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fmt_q  <= spcs_pkg::FMT_RST;
         rate_q <= spcs_pkg::RATE_RST;
         txb_q  <= spcs_pkg::TXB_RST;
      end else begin
         if (w_fmt) fmt_q <= wdata[7:0];
         if (w_rate) rate_q <= wdata[7:0];
         if (w_txb) txb_q <= wdata[7:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (clr) begin
         ctrl_q <= spcs_pkg::CTRL_RST;
      end else begin
         if (w_ctrl) ctrl_q <= wdata[7:0];
         // [R8] Waiting ends automatically.
         if (rx_keep && mp_act && rx_extra) begin
            ctrl_q.multi_cpu_wait_enable <= 1'b0;
         end
      end
   end

   assign pre_tick  = (pre_q & pre_mask(fmt_q.prescale)) ==
                      pre_mask(fmt_q.prescale);
   assign base_tick = pre_tick && div_q == rate_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre_q <= 6'h00;
         div_q <= 8'h00;
      end else begin
         pre_q <= pre_q + 6'h01;
         if (pre_tick) div_q <= base_tick ? 8'h00 : div_q + 8'h01;
      end
   end

   assign sync     = fmt_q.sync_mode;
   assign ck_sel   = {ctrl_q.clk_src_external, ctrl_q.clk_out_select};
   assign ext_rise = ck_sel == spcs_pkg::CK_EXT && sck_f && !sck_p_q;
   assign run      = tx_st_q == spcs_pkg::TX_SHIFT ||
                     (ctrl_q.rx_enable && rx_ok);
   // [R12] Synchronous clock source.
   assign sck_rise = sync && (ext_rise || (ck_sel == spcs_pkg::CK_INT_IO &&
                     base_tick && run && !int_sck_q));
   // [R11] Asynchronous clock source.
   assign os_tick  = !sync && (ck_sel[1] ? ext_rise : base_tick);

   always_ff @(posedge aclk) begin
      if (clr) begin
         int_sck_q  <= 1'b1;
         ck_os_q    <= 4'h0;
         sck_out_q  <= 1'b1;
         sck_oe_n_q <= 1'b1;
      end else begin
         if (!run) int_sck_q <= 1'b1;
         else if (base_tick) int_sck_q <= !int_sck_q;
         if (os_tick) ck_os_q <= ck_os_q + 4'h1;
         // [R13] One period per sixteen ticks, or per two base ticks when sync.
         sck_out_q  <= sync ? int_sck_q : ck_os_q[3];
         sck_oe_n_q <= !(sync ? ck_sel == spcs_pkg::CK_INT_IO
                              : ck_sel == spcs_pkg::CK_INT_OUT);
      end
   end

   assign tx_bit_ev = sync ? sck_rise : (os_tick && tx_os_q == spcs_pkg::OS_LAST);
   assign tx_last   = tx_st_q == spcs_pkg::TX_SHIFT && tx_bit_ev &&
                      tx_left_q == 4'h1;
   // [R2] Load waiting data.
   assign tx_load   = ctrl_q.tx_enable && !stat_q.tx_buffer_empty && !w_txb &&
                      (tx_st_q == spcs_pkg::TX_IDLE || tx_last);

   always_ff @(posedge aclk) begin
      // [R1] No sending while disabled.
      if (clr || !ctrl_q.tx_enable) begin
         tx_st_q   <= spcs_pkg::TX_IDLE;
         tx_sh_q   <= 12'hfff;
         tx_left_q <= 4'h0;
         tx_os_q   <= 4'h0;
      end else if (tx_load) begin
         tx_st_q   <= spcs_pkg::TX_SHIFT;
         tx_sh_q   <= tx_frame(fmt_q, txb_q, stat_q.multi_cpu_bit_to_send);
         tx_left_q <= sync ? spcs_pkg::BITS_SYNC
                           : frame_bits(fmt_q) + 4'h1 + {3'h0, fmt_q.stop2};
         tx_os_q   <= 4'h0;
      end else if (tx_st_q == spcs_pkg::TX_SHIFT) begin
         if (os_tick) tx_os_q <= tx_os_q + 4'h1;
         if (tx_bit_ev) begin
            tx_sh_q   <= {1'b1, tx_sh_q[11:1]};
            tx_left_q <= tx_left_q - 4'h1;
            if (tx_last) tx_st_q <= spcs_pkg::TX_IDLE;
         end
      end
   end

   assign rx_ok   = ctrl_q.rx_enable && !stat_q.overrun_flag &&
                    !stat_q.framing_flag && !stat_q.parity_flag;
   // [R5] Clock edge or mid-bit sample.
   assign rx_take = sync ? (sck_rise && (rx_st_q == spcs_pkg::RX_DATA ||
                            (rx_st_q == spcs_pkg::RX_IDLE && rx_ok)))
                         : (rx_st_q == spcs_pkg::RX_DATA && os_tick &&
                            rx_os_q == spcs_pkg::OS_LAST);
   assign rx_done = rx_take && rx_idx_q == frame_bits(fmt_q) - 4'h1;

   always_comb begin
      rx_full = rx_bits_q;
      rx_full[rx_idx_q] = rxd_f;
   end

   assign rx_n     = data_bits(fmt_q);
   assign rx_ex    = has_extra(fmt_q);
   assign rx_data  = (rx_n == 4'h7) ? {1'b0, rx_full[6:0]} : rx_full[7:0];
   assign rx_extra = rx_full[rx_n];
   assign rx_stop  = rx_full[rx_n+{3'h0, rx_ex}];
   // [R6] Wait only in asynchronous multiprocessor.
   assign mp_act   = !sync && fmt_q.multi_cpu_mode;
   // [R7] Drop unaddressed characters.
   assign rx_drop  = mp_act && ctrl_q.multi_cpu_wait_enable && !rx_extra;
   assign rx_keep  = rx_done && !rx_drop;
   assign set_oer  = rx_keep && stat_q.rx_buffer_full;
   assign set_fer  = rx_keep && !sync && !rx_stop;
   assign set_per  = rx_keep && !sync && fmt_q.parity_en && !mp_act &&
                     ((^rx_data) ^ rx_extra) != fmt_q.parity_odd;
   assign rx_fill  = rx_keep && !set_oer && !set_fer && !set_per;

   always_ff @(posedge aclk) begin
      // [R4] Receive off stops reception.
      if (clr || !ctrl_q.rx_enable) begin
         rx_st_q   <= spcs_pkg::RX_IDLE;
         rx_bits_q <= 10'h3ff;
         rx_idx_q  <= 4'h0;
         rx_os_q   <= 4'h0;
      end else begin
         case (rx_st_q)
            spcs_pkg::RX_IDLE: begin
               rx_idx_q <= 4'h0;
               if (rx_take) begin
                  rx_bits_q <= rx_full;
                  rx_idx_q  <= 4'h1;
                  rx_st_q   <= spcs_pkg::RX_DATA;
               end else if (!sync && rx_ok && !rxd_f) begin
                  rx_os_q <= 4'h0;
                  rx_st_q <= spcs_pkg::RX_START;
               end
            end
            spcs_pkg::RX_START: begin
               if (os_tick) begin
                  rx_os_q <= rx_os_q + 4'h1;
                  if (rx_os_q == spcs_pkg::OS_MID) begin
                     rx_os_q <= 4'h0;
                     rx_st_q <= rxd_f ? spcs_pkg::RX_IDLE
                                      : spcs_pkg::RX_DATA;
                  end
               end
            end
            spcs_pkg::RX_DATA: begin
               if (os_tick) rx_os_q <= rx_os_q + 4'h1;
               if (rx_take) begin
                  rx_bits_q <= rx_full;
                  rx_idx_q  <= rx_idx_q + 4'h1;
                  if (rx_done) begin
                     rx_idx_q <= 4'h0;
                     rx_st_q  <= spcs_pkg::RX_IDLE;
                  end
               end
            end
            default: rx_st_q <= spcs_pkg::RX_IDLE;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rxb_q <= 8'h00;
      end else if (rx_keep && !set_oer) begin
         rxb_q <= rx_data;
      end
   end

   // [R18] Zero write clears armed flags only.
   assign wclr = (w_stat ? ~wdata[7:3] : 5'h00) & arm_q;

   always_comb begin
      stat_d = stat_q;
      stat_d[7:3] = stat_q[7:3] & ~wclr;
      // [R21] Buffer write empties flag; disable below sets it again.
      if (w_txb) stat_d.tx_buffer_empty = 1'b0;
      if (rd_rxb) stat_d.rx_buffer_full = 1'b0;
      // [R19] Only the send bit writable.
      if (w_stat) stat_d.multi_cpu_bit_to_send = wdata[0];
      // [R20] Transfer or disable sets empty.
      if (tx_load || !ctrl_q.tx_enable) stat_d.tx_buffer_empty = 1'b1;
      // [R10] Complete falls with empty.
      if (stat_q.tx_buffer_empty && !stat_d.tx_buffer_empty) begin
         stat_d.tx_complete_flag = 1'b0;
      end
      // [R9] Last bit, nothing waiting.
      if (tx_last && !tx_load) stat_d.tx_complete_flag = 1'b1;
      // [R22] Clean character fills buffer.
      if (rx_fill) stat_d.rx_buffer_full = 1'b1;
      if (set_oer) stat_d.overrun_flag = 1'b1;
      if (set_fer) stat_d.framing_flag = 1'b1;
      if (set_per) stat_d.parity_flag = 1'b1;
      // [R8] Record received bit.
      if (rx_keep && mp_act) stat_d.multi_cpu_bit_received = rx_extra;
   end

   always_ff @(posedge aclk) begin
      // [R17] Reset and low power value.
      if (clr) begin
         stat_q <= spcs_pkg::STAT_RST;
         arm_q  <= 5'h00;
      end else begin
         stat_q <= stat_d;
         // [R23] Arm on a read of one.
         arm_q  <= (arm_q | (rd_stat ? stat_q[7:3] : 5'h00)) & stat_d[7:3];
      end
   end

   always_ff @(posedge aclk) begin
      if (clr) begin
         txd_q  <= 1'b1;
         rxps_q <= 1'b0;
         irq_q  <= 4'h0;
      end else begin
         txd_q  <= tx_st_q == spcs_pkg::TX_SHIFT ? tx_sh_q[0] : 1'b1;
         rxps_q <= ctrl_q.rx_enable;
         irq_q  <= {ctrl_q.tx_empty_irq_enable & stat_q.tx_buffer_empty,
                    ctrl_q.rx_irq_enable & stat_q.rx_buffer_full,
                    ctrl_q.rx_irq_enable & (stat_q.overrun_flag |
                       stat_q.framing_flag | stat_q.parity_flag),
                    ctrl_q.tx_done_irq_enable & stat_q.tx_complete_flag};
      end
   end

   assign awready        = awready_q;
   assign wready         = wready_q;
   assign bvalid         = bvalid_q;
   assign bresp          = bresp_q;
   assign arready        = arready_q;
   assign rvalid         = rvalid_q;
   assign rresp          = rresp_q;
   assign rdata          = {24'h000000, rdata_q};
   assign txd            = txd_q;
   assign rxd_pin_serial = rxps_q;
   assign sck_out        = sck_out_q;
   assign sck_oe_n       = sck_oe_n_q;
   assign tx_empty_irq   = irq_q[3];
   assign rx_full_irq    = irq_q[2];
   assign rx_fault_irq   = irq_q[1];
   assign tx_done_irq    = irq_q[0];
endmodule
